// *** usb_fifo_cfg.svh ***
`ifndef USB_FIFO_CFG_SVH
`define USB_FIFO_CFG_SVH

// ****************************************************
// clock and widths
// ****************************************************
`define CLK_PERIOD_NS   10
`define DATA_W          8
`define CNT_W           22
`define FLAG_W          3

// ****************************************************
// flag vector positions
// ****************************************************
`define FLAG_RX_POS     2
`define FLAG_TX_POS     1
`define FLAG_PWR_POS    0

// ****************************************************
// reset values
// ****************************************************
`define FLAG_RESET      3'h7
`define DATA_RESET      8'h00

// ****************************************************
// pin timing in nanoseconds and milliseconds
// ****************************************************
`define RD_LOW_NS       80
`define WR_HIGH_NS      80
`define RECOVER_NS      80
`define WAKE_MS         20
`define NS_PER_MS       1000000

`endif

// *** usb_fifo_pkg.sv ***
package usb_fifo_pkg;

`include "usb_fifo_cfg.svh"

  typedef logic [`DATA_W-1:0] byte_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RD_LOW   = 3'b001,
    ST_RD_REC   = 3'b010,
    ST_WR_SETUP = 3'b011,
    ST_WR_HIGH  = 3'b100,
    ST_WR_HOLD  = 3'b101,
    ST_WR_REC   = 3'b110,
    ST_WAKE     = 3'b111
  } host_state_e;

  typedef struct packed {
    host_state_e        state;
    logic [`CNT_W-1:0]  cnt;
    logic [`FLAG_W-1:0] flag_meta;
    logic [`FLAG_W-1:0] flag_sync;
    byte_t              data_meta;
    byte_t              data_sync;
    logic               rd_n;
    logic               wr;
    logic               data_oe;
    byte_t              data_out;
    logic               wake_oe;
    logic               dev_rst_n;
    logic               last_rd;
    logic               push;
    byte_t              rx_byte;
  } host_s;

  typedef struct packed {
    byte_t [1:0] mem;
    logic  [1:0] count;
  } buf_s;

endpackage

// *** byte_stream_if.sv ***
`timescale 1ns/1ps

interface byte_stream_if;
  logic                 valid;
  logic                 ready;
  usb_fifo_pkg::byte_t  data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** two_entry_buf.sv ***
`timescale 1ns/1ps

module two_entry_buf (
  input  wire logic   i_clk_sys,
  input  wire logic   i_reset,
  input  wire logic   i_clk_en,
  byte_stream_if.snk  in_s,
  byte_stream_if.src  out_s
);

  // ****************************************************
  // state
  // ****************************************************
  usb_fifo_pkg::buf_s buf_r;
  usb_fifo_pkg::buf_s buf_nxt;
  logic               push;
  logic               pop;
  logic [1:0]         fill;

  // full and empty come straight from the count
  assign in_s.ready  = (buf_r.count != 2'h2);
  assign out_s.valid = (buf_r.count != 2'h0);
  assign out_s.data  = buf_r.mem[0];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  // ****************************************************
  // shift buffer, head always in entry 0
  // ****************************************************
  always_comb begin
    buf_nxt = buf_r;
    fill    = buf_r.count - {1'b0, pop};
    if (pop) begin
      buf_nxt.mem[0] = buf_r.mem[1];
    end
    if (push) begin
      buf_nxt.mem[fill[0]] = in_s.data;
    end
    buf_nxt.count = fill + {1'b0, push};
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      buf_r <= '0;
    end else if (i_clk_en) begin
      buf_r <= buf_nxt;
    end
  end

endmodule // two_entry_buf

// *** usb_fifo_host.sv ***
`timescale 1ns/1ps

`include "usb_fifo_cfg.svh"

// How it works
// - the host never raises a write strobe while the space flag is high.
// - with the space flag low the host writes by pulsing write high then low.
// - the host never lowers the read strobe while the data flag is high.
// - with the data flag low the host reads by pulsing read low then high.
// - to wake the bus the host holds that pin low for at least 20 ms.

module usb_fifo_host #(
  parameter int WAKE_CYCLES = `WAKE_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset,
  input  wire logic              i_clk_en,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  input  wire logic [`DATA_W-1:0] i_tx_data,
  output logic                   o_rx_valid,
  input  wire logic              i_rx_ready,
  output logic [`DATA_W-1:0]     o_rx_data,
  input  wire logic              i_remote_wake_en,
  input  wire logic              i_wake_req,
  input  wire logic              i_dev_reset_req,
  output logic                   o_configured,
  output logic                   o_suspended,
  output logic                   o_wake_busy,
  output logic                   o_device_reset_n,
  output logic                   o_rd_n,
  output logic                   o_wr,
  input  wire logic [`DATA_W-1:0] i_data_bus,
  output logic [`DATA_W-1:0]     o_data_bus,
  output logic                   o_data_bus_oe,
  input  wire logic              i_rx_data_flag_n,
  output logic                   o_rx_data_flag_n,
  output logic                   o_rx_data_flag_n_oe,
  input  wire logic              i_tx_space_flag_n,
  input  wire logic              i_power_enable_n
);

  // ****************************************************
  // timing counts
  // ****************************************************
  localparam int RD_LOW_CYC  =
    (`RD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int WR_HIGH_CYC =
    (`WR_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int RECOVER_CYC =
    (`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  localparam logic [`CNT_W-1:0] RD_LOW_LAST  = `CNT_W'(RD_LOW_CYC - 1);
  localparam logic [`CNT_W-1:0] WR_HIGH_LAST = `CNT_W'(WR_HIGH_CYC - 1);
  localparam logic [`CNT_W-1:0] RECOVER_LAST = `CNT_W'(RECOVER_CYC - 1);
  localparam logic [`CNT_W-1:0] WAKE_LAST    = `CNT_W'(WAKE_CYCLES - 1);

  localparam usb_fifo_pkg::host_s HOST_RESET = '{
    state:     usb_fifo_pkg::ST_IDLE,
    cnt:       '0,
    flag_meta: `FLAG_RESET,
    flag_sync: `FLAG_RESET,
    data_meta: `DATA_RESET,
    data_sync: `DATA_RESET,
    rd_n:      1'b1,
    wr:        1'b0,
    data_oe:   1'b0,
    data_out:  `DATA_RESET,
    wake_oe:   1'b0,
    dev_rst_n: 1'b0,
    last_rd:   1'b0,
    push:      1'b0,
    rx_byte:   `DATA_RESET
  };

  // ****************************************************
  // state and decoded conditions
  // ****************************************************
  usb_fifo_pkg::host_s st_r;
  usb_fifo_pkg::host_s st_nxt;

  byte_stream_if rx_in ();
  byte_stream_if rx_out ();

  logic rx_avail;
  logic tx_space;
  logic suspended;
  logic wake_pin_mode;
  logic can_read;
  logic can_write;
  logic can_wake;
  logic read_first;
  logic idle;

  // flags are active low on the pins
  assign rx_avail      = ~st_r.flag_sync[`FLAG_RX_POS];
  assign tx_space      = ~st_r.flag_sync[`FLAG_TX_POS];
  assign suspended     = st_r.flag_sync[`FLAG_PWR_POS];
  assign wake_pin_mode = i_remote_wake_en & suspended;
  assign idle          = (st_r.state == usb_fifo_pkg::ST_IDLE);

  // no transfers while device in reset
  // read only when data flag low
  assign can_read  = st_r.dev_rst_n & ~wake_pin_mode & rx_avail &
                     rx_in.ready;
  // write only when space flag low
  assign can_write = st_r.dev_rst_n & tx_space & i_tx_valid;
  assign can_wake  = st_r.dev_rst_n & wake_pin_mode & i_wake_req;

  // alternate between directions when both are pending
  assign read_first = ~st_r.last_rd | ~can_write;

  // no handshake while frozen, so no byte is lost
  assign o_tx_ready = idle & ~can_wake & ~(can_read & read_first) &
                      can_write & i_clk_en;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.push = 1'b0;

    // two-stage synchronisers on every pin input
    st_nxt.flag_meta = {i_rx_data_flag_n, i_tx_space_flag_n,
                        i_power_enable_n};
    st_nxt.flag_sync = st_r.flag_meta;
    st_nxt.data_meta = i_data_bus;
    st_nxt.data_sync = st_r.data_meta;

    st_nxt.dev_rst_n = ~i_dev_reset_req;

    unique case (st_r.state)
      usb_fifo_pkg::ST_IDLE: begin
        st_nxt.cnt = '0;
        if (can_wake) begin
          st_nxt.wake_oe = 1'b1;
          st_nxt.state   = usb_fifo_pkg::ST_WAKE;
        end else if (can_read && read_first) begin
          st_nxt.rd_n    = 1'b0;
          st_nxt.last_rd = 1'b1;
          st_nxt.state   = usb_fifo_pkg::ST_RD_LOW;
        end else if (can_write) begin
          st_nxt.data_out = i_tx_data;
          st_nxt.data_oe  = 1'b1;
          st_nxt.last_rd  = 1'b0;
          st_nxt.state    = usb_fifo_pkg::ST_WR_SETUP;
        end
      end

      usb_fifo_pkg::ST_RD_LOW: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == RD_LOW_LAST) begin
          st_nxt.rx_byte = st_r.data_sync;
          st_nxt.push    = 1'b1;
          st_nxt.rd_n    = 1'b1;
          st_nxt.cnt     = '0;
          st_nxt.state   = usb_fifo_pkg::ST_RD_REC;
        end
      end

      usb_fifo_pkg::ST_RD_REC: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == RECOVER_LAST) begin
          st_nxt.state = usb_fifo_pkg::ST_IDLE;
        end
      end

      usb_fifo_pkg::ST_WR_SETUP: begin
        st_nxt.wr    = 1'b1;
        st_nxt.cnt   = '0;
        st_nxt.state = usb_fifo_pkg::ST_WR_HIGH;
      end

      usb_fifo_pkg::ST_WR_HIGH: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == WR_HIGH_LAST) begin
          st_nxt.wr    = 1'b0;
          st_nxt.state = usb_fifo_pkg::ST_WR_HOLD;
        end
      end

      usb_fifo_pkg::ST_WR_HOLD: begin
        // data held one cycle past the fall
        st_nxt.data_oe = 1'b0;
        st_nxt.cnt     = '0;
        st_nxt.state   = usb_fifo_pkg::ST_WR_REC;
      end

      usb_fifo_pkg::ST_WR_REC: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == RECOVER_LAST) begin
          st_nxt.state = usb_fifo_pkg::ST_IDLE;
        end
      end

      usb_fifo_pkg::ST_WAKE: begin
        if (st_r.wake_oe) begin
          st_nxt.cnt = st_r.cnt + 1'b1;
          if (st_r.cnt == WAKE_LAST) begin
            st_nxt.wake_oe = 1'b0;
          end
        end else if (!i_wake_req) begin
          st_nxt.state = usb_fifo_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st_r <= HOST_RESET;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************
  // receive buffer
  // ****************************************************
  assign rx_in.valid  = st_r.push;
  assign rx_in.data   = st_r.rx_byte;
  assign rx_out.ready = i_rx_ready;
  assign o_rx_valid   = rx_out.valid & i_clk_en;
  assign o_rx_data    = rx_out.data;

  two_entry_buf u_rx_buf (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_clk_en  (i_clk_en),
    .in_s      (rx_in),
    .out_s     (rx_out)
  );

  // ****************************************************
  // pins and status
  // ****************************************************
  assign o_device_reset_n    = st_r.dev_rst_n;
  assign o_rd_n              = st_r.rd_n;
  assign o_wr                = st_r.wr;
  assign o_data_bus          = st_r.data_out;
  assign o_data_bus_oe       = st_r.data_oe;
  assign o_rx_data_flag_n    = 1'b0;
  assign o_rx_data_flag_n_oe = st_r.wake_oe;
  assign o_configured        = ~suspended;
  assign o_suspended         = suspended;
  assign o_wake_busy         = (st_r.state == usb_fifo_pkg::ST_WAKE);

endmodule // usb_fifo_host

// *** usb_fifo_host_props.sv ***
`timescale 1ns/1ps
module usb_fifo_host_props #(parameter int WAKE_CYCLES = 20) (
  input wire logic       i_clk_sys,
  input wire logic       i_reset,
  input wire logic       i_dev_reset_req,
  input wire logic       o_configured,
  input wire logic       o_suspended,
  input wire logic       o_device_reset_n,
  input wire logic       o_rd_n,
  input wire logic       o_wr,
  input wire logic [7:0] o_data_bus,
  input wire logic       o_data_bus_oe,
  input wire logic       o_rx_data_flag_n_oe,
  input wire logic       i_tx_space_flag_n,
  input wire logic       i_power_enable_n
);
  // ****
  // strobe and pin checks
  // ****
  int wake_n;
  always_ff @(posedge i_clk_sys)
    if (i_reset) wake_n <= 0;
    else wake_n <= o_rx_data_flag_n_oe ? wake_n + 1 : 0;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence s_rd_low; (!o_rd_n) [*8]; endsequence
  sequence s_wr_high; o_wr [*8]; endsequence
  property p_pwr;
    (!i_power_enable_n) [*4] |-> o_configured && !o_suspended;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power state");
  property p_no_fight; !o_rd_n |-> !o_data_bus_oe; endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus fight");
  property p_wr_data; $fell(o_wr) |-> o_data_bus_oe && $stable(o_data_bus);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data");
  property p_wr_full; i_tx_space_flag_n [*8] |-> !$rose(o_wr); endproperty
  a_wr_full: assert property (p_wr_full) else $error("write when full");
  property p_wr_pulse;
    $rose(o_wr) |-> o_data_bus_oe throughout (s_wr_high ##1 !o_wr);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse");
  property p_rd_pulse; $fell(o_rd_n) |-> s_rd_low ##1 o_rd_n; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse");
  property p_wake;
    $fell(o_rx_data_flag_n_oe) |-> wake_n >= WAKE_CYCLES;
  endproperty
  a_wake: assert property (p_wake) else $error("wake too short");
  property p_dev_rst; i_dev_reset_req |=> !o_device_reset_n; endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("device reset");
endmodule // usb_fifo_host_props

bind usb_fifo_host usb_fifo_host_props #(
  .WAKE_CYCLES (WAKE_CYCLES)
) u_props (
  .i_clk_sys           (i_clk_sys),
  .i_reset             (i_reset),
  .i_dev_reset_req     (i_dev_reset_req),
  .o_configured        (o_configured),
  .o_suspended         (o_suspended),
  .o_device_reset_n    (o_device_reset_n),
  .o_rd_n              (o_rd_n),
  .o_wr                (o_wr),
  .o_data_bus          (o_data_bus),
  .o_data_bus_oe       (o_data_bus_oe),
  .o_rx_data_flag_n_oe (o_rx_data_flag_n_oe),
  .i_tx_space_flag_n   (i_tx_space_flag_n),
  .i_power_enable_n    (i_power_enable_n)
);

// *** usb_fifo_dev_model.sv ***
`timescale 1ns/1ps
module usb_fifo_dev_model #(
  parameter int DEPTH    = 4,
  parameter int WAKE_MIN = 20,
  parameter int PULL_LOW = 1
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_cfg,
  input  wire logic       i_susp,
  input  wire logic       i_wake_opt,
  input  wire logic       i_drain,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_bus,
  input  wire logic       i_rxf_pin,
  output logic      [7:0] o_bus,
  output logic            o_rxf_n,
  output logic            o_rxf_oe,
  output logic            o_txe_n,
  output logic            o_pwr_n
);
  // ****
  // device pins
  // ****
  logic [7:0] rxq[$], got[$], cur, idle = 8'h5a;
  int         fill = 0, low_cnt = 0, resumes = 0;
  assign o_pwr_n = !i_cfg || i_susp;
  assign o_rxf_oe = !(i_wake_opt && o_pwr_n);
  assign o_bus = !i_rd_n ? cur : (PULL_LOW != 0 && o_pwr_n) ? 8'h00 : idle;
  always @(negedge i_rd_n)
    if (i_reset_n && rxq.size() > 0) cur = rxq.pop_front();
  always @(negedge i_wr) if (i_reset_n && !o_txe_n) begin
    got.push_back(i_bus);
    fill++;
  end
  always @(posedge i_clk_sys) begin
    idle <= ~idle;
    if (!i_reset_n || i_drain) fill = 0;
    o_rxf_n <= !i_reset_n || rxq.size() == 0;
    o_txe_n <= !i_reset_n || fill >= DEPTH;
    if (o_rxf_oe || i_rxf_pin) begin
      if (low_cnt >= WAKE_MIN) resumes++;
      low_cnt = 0;
    end else low_cnt++;
  end
endmodule // usb_fifo_dev_model

// *** tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t got %h exp %h", $time, a, e); end end
module tb;
  logic       i_clk_sys = 0, i_reset = 1, i_tx_valid = 0, i_rx_ready = 0;
  logic       i_remote_wake_en = 0, i_wake_req = 0, i_dev_reset_req = 0;
  logic       cfg = 0, susp = 0, drain = 0, o_tx_ready, o_rx_valid;
  logic       o_configured, o_suspended, o_wake_busy, o_device_reset_n;
  logic       o_rd_n, o_wr, o_data_bus_oe, rxf_o, rxf_oe, dev_rxf, dev_oe;
  logic       txe_n, pwr_n, clk_en = 1, hold_rx = 0;
  logic [7:0] i_tx_data = 0, o_rx_data, o_data_bus, dev_bus, b, e;
  logic [7:0] exp_rx[$], exp_tx[$];
  int         mismatches = 0, n_tests = 0, cyc = 0;
  wire  [7:0] bus_w = o_data_bus_oe ? o_data_bus : dev_bus;
  wire        rxf_w = rxf_oe ? rxf_o : dev_oe ? dev_rxf : 1'b1;

  usb_fifo_host #(.WAKE_CYCLES(20)) u_dut (
    .i_clk_sys, .i_reset, .i_clk_en(clk_en), .i_tx_valid, .o_tx_ready,
    .i_tx_data, .o_rx_valid, .i_rx_ready, .o_rx_data, .i_remote_wake_en,
    .i_wake_req, .i_dev_reset_req, .o_configured, .o_suspended, .o_wake_busy,
    .o_device_reset_n, .o_rd_n, .o_wr, .i_data_bus(bus_w), .o_data_bus,
    .o_data_bus_oe, .i_rx_data_flag_n(rxf_w), .o_rx_data_flag_n(rxf_o),
    .o_rx_data_flag_n_oe(rxf_oe), .i_tx_space_flag_n(txe_n),
    .i_power_enable_n(pwr_n));
  usb_fifo_dev_model u_dev (
    .i_clk_sys, .i_reset_n(o_device_reset_n), .i_cfg(cfg), .i_susp(susp),
    .i_wake_opt(i_remote_wake_en), .i_drain(drain), .i_rd_n(o_rd_n),
    .i_wr(o_wr), .i_bus(bus_w), .i_rxf_pin(rxf_w), .o_bus(dev_bus),
    .o_rxf_n(dev_rxf), .o_rxf_oe(dev_oe), .o_txe_n(txe_n), .o_pwr_n(pwr_n));

  // ****
  // clock, stall and checks
  // ****
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    i_rx_ready <= !hold_rx && (($urandom % 3) != 0);
    if (++cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  always @(negedge i_clk_sys) if (o_rx_valid === 1'b1 && i_rx_ready) begin
    e = exp_rx.pop_front();
    `CHK(o_rx_data, e)
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic send(input logic [7:0] d);
    @(posedge i_clk_sys);
    i_tx_valid <= 1;
    i_tx_data <= d;
    do @(negedge i_clk_sys); while (o_tx_ready !== 1'b1);
    @(posedge i_clk_sys);
    i_tx_valid <= 0;
    exp_tx.push_back(d);
  endtask

  // ****
  // tests
  // ****
  initial begin
    void'($urandom(32'h0000_349b));
    tick(4);
    i_reset <= 0;
    cfg <= 1;
    tick(5);
    `CHK(o_configured, 1'b1)
    $display("test power done");
    hold_rx <= 1;
    repeat (10) begin
      b = 8'($urandom);
      u_dev.rxq.push_back(b);
      exp_rx.push_back(b);
    end
    fork
      repeat (6) send(8'($urandom));
    join_none
    tick(200);
    `CHK(u_dev.rxq.size(), 8)
    `CHK(o_rx_valid, 1'b1)
    hold_rx <= 0;
    tick(200);
    `CHK(u_dev.got.size(), 4)
    drain <= 1;
    tick(1);
    drain <= 0;
    wait fork;
    wait (exp_rx.size() == 0);
    tick(60);
    `CHK(u_dev.got.size(), 6)
    foreach (exp_tx[i]) `CHK(u_dev.got[i], exp_tx[i])
    $display("test traffic done");
    clk_en <= 0;
    i_tx_valid <= 1;
    tick(5);
    `CHK(o_tx_ready, 1'b0)
    `CHK(o_wr, 1'b0)
    clk_en <= 1;
    i_tx_valid <= 0;
    tick(30);
    `CHK(u_dev.got.size(), 6)
    $display("test freeze done");
    i_dev_reset_req <= 1;
    tick(3);
    `CHK(o_device_reset_n, 1'b0)
    i_dev_reset_req <= 0;
    tick(3);
    `CHK(o_device_reset_n, 1'b1)
    $display("test device reset done");
    i_remote_wake_en <= 1;
    susp <= 1;
    tick(5);
    `CHK(o_suspended, 1'b1)
    i_wake_req <= 1;
    tick(10);
    `CHK(rxf_w, 1'b0)
    `CHK(o_wake_busy, 1'b1)
    tick(30);
    i_wake_req <= 0;
    tick(5);
    `CHK(u_dev.resumes, 1)
    `CHK(o_wake_busy, 1'b0)
    i_remote_wake_en <= 0;
    i_wake_req <= 1;
    tick(40);
    `CHK(u_dev.resumes, 1)
    `CHK(rxf_oe, 1'b0)
    i_wake_req <= 0;
    $display("test wake done");
    close_out();
  end
endmodule // tb
